// *** include/np_spi_defines.svh ***
// Constants for the network processor SPI slave transaction engine
`ifndef NP_SPI_DEFINES_SVH
`define NP_SPI_DEFINES_SVH

// ****************************************
// Framing
// ****************************************
`define NP_IDLE_BYTE       8'hFF
`define NP_BYTE_LAST_BIT   3'h7
`define NP_BIT_FIRST       3'h0
`define NP_FRAME_MIN       8'h02
`define NP_FRAME_MAX       8'h88
`define NP_COUNT_ONE       8'h01

// ****************************************
// Timing
// ****************************************
`define NP_CLK_HZ          25000000
`define NP_WAIT_MAX_MS     300
`define NP_WAIT_CYCLES     (`NP_WAIT_MAX_MS * (`NP_CLK_HZ / 1000))
`define NP_WAIT_CNT_W      23

// ****************************************
// Buffering
// ****************************************
`define NP_RSP_FIFO_DEPTH  4

`endif

// *** include/np_spi_pkg.sv ***
// Types shared by the SPI slave transaction engine
`default_nettype none

package np_spi_pkg;

  // Gray codes along idle, command, wait, response, tail, done
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'h0,
    PH_CMD  = 3'h1,
    PH_WAIT = 3'h3,
    PH_RSP  = 3'h2,
    PH_TAIL = 3'h6,
    PH_DONE = 3'h7
  } phase_t;

  // One response byte with its end-of-frame marker
  typedef struct packed
  {
    logic       last;
    logic [7:0] data;
  } rsp_word_t;

endpackage : np_spi_pkg

`default_nettype wire

// *** logic/np_byte_fifo.sv ***
// Small flop-based FIFO with valid/ready on both sides and a flush
`default_nettype none

module np_byte_fifo
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in & in_ready_out & ~flush_in;
  assign pop           = out_valid_out & out_ready_in & ~flush_in;

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  // ****************************************
  // Pointers and fill level
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      if (push & ~pop)
        count <= CW'(count + 1'b1);
      else if (pop & ~push)
        count <= CW'(count - 1'b1);
    end
  end

endmodule : np_byte_fifo

`default_nettype wire

// *** logic/np_spi_slave.sv ***
// SPI slave transaction engine: command, wait and response phases
//
// Behaviour
// RQ1: Slave in clock mode 0 or 3; MOSI sampled on rising clock edge.
// RQ2: Host keeps the serial clock at 5 MHz or slower.
// RQ3: Attention output and wake input are asserted low, idle high.
// RQ4: Wake input has an internal pull-up so it idles high.
// RQ5: Only the host starts transfers; the device never does.
// RQ6: Half-duplex transaction: command, then wait, then response.
// RQ7: Host selects, then sends 2 to 136 command bytes, first not 0xFF.
// RQ8: During command bytes the device returns only 0xFF.
// RQ9: Wait phase lasts at most 300 ms.
// RQ10: During wait, send only 0xFF and discard incoming bytes.
// RQ11: First non-0xFF byte starts the response; host may poll for it.
// RQ12: Attention goes low when a response is ready.
// RQ13: Attention returns high once the host clocks again.
// RQ14: Response is 2 to 136 bytes and never starts with 0xFF. A first word marked last still ends the response after 1 byte.
// RQ15: Host clocks exactly the response length it decodes.
// RQ16: No acknowledge; every clocked response byte counts as taken.
// RQ17: Host keeps select high 1 ms between transactions.
// RQ18: Select released before completion drops the transaction.
// RQ19: Bytes move MSB first, eight clocks each, while selected.
`default_nettype none
`include "np_spi_defines.svh"

module np_spi_slave
#(
  parameter int unsigned WAIT_CYCLES = `NP_WAIT_CYCLES
)
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  spi_sclk_in,
  input  wire logic                  spi_ss_n_in,
  input  wire logic                  spi_mosi_in,
  output logic                       spi_miso_out,
  output logic                       spi_miso_oe_out,
  output logic                       host_attention_n_out,
  input  wire logic                  wake_request_n_in,
  output logic                       wake_pullup_en_out,
  output logic                       wake_req_out,
  output logic                       cmd_valid_out,
  output logic [7:0]                 cmd_data_out,
  input  wire logic                  cmd_end_in,
  input  wire logic                  rsp_valid_in,
  output logic                       rsp_ready_out,
  input  wire np_spi_pkg::rsp_word_t rsp_word_in,
  output logic                       txn_done_out,
  output logic                       txn_abort_out,
  output logic                       wait_overrun_out,
  output logic                       rsp_underrun_out,
  output np_spi_pkg::phase_t         phase_out
);

  np_spi_pkg::phase_t        phase;
  np_spi_pkg::rsp_word_t     fifo_word;
  logic [1:0]                sclk_sync;
  logic [1:0]                ss_sync;
  logic [1:0]                mosi_sync;
  logic [1:0]                wake_sync;
  logic                      sclk_prev;
  logic                      ss_prev;
  logic                      selected;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      ss_fall;
  logic                      ss_rise;
  logic [2:0]                bit_cnt;
  logic                      armed;
  logic [7:0]                rx_shift;
  logic [7:0]                tx_shift;
  logic                      byte_done;
  logic                      boundary;
  logic [7:0]                cmd_cnt;
  logic [7:0]                rsp_cnt;
  logic [`NP_WAIT_CNT_W-1:0] wait_cnt;
  logic                      attn_armed;
  logic                      fifo_valid;
  logic                      rsp_ready_now;
  logic                      skip_ff;
  logic                      take_first;
  logic                      take_next;
  logic                      rsp_end;
  logic                      pop;
  logic                      abort;

  // ****************************************
  // Pin synchronisers and edge finding
  // ****************************************
  // Only the second flop of each pair is read by logic
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_sync <= 2'h0;
      ss_sync   <= 2'h3;
      mosi_sync <= 2'h0;
      wake_sync <= 2'h3;
      sclk_prev <= 1'b0;
      ss_prev   <= 1'b1;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], spi_sclk_in};
      ss_sync   <= {ss_sync[0], spi_ss_n_in};
      mosi_sync <= {mosi_sync[0], spi_mosi_in};
      wake_sync <= {wake_sync[0], wake_request_n_in};
      sclk_prev <= sclk_sync[1];
      ss_prev   <= ss_sync[1];
    end
  end

  assign selected  = ~ss_sync[1];
  assign ss_fall   = ~ss_sync[1] & ss_prev;
  assign ss_rise   = ss_sync[1] & ~ss_prev;
  // Edges count only while selected, so either idle level works
  assign sclk_rise = selected & sclk_sync[1] & ~sclk_prev; // RQ1
  assign sclk_fall = selected & ~sclk_sync[1] & sclk_prev; // RQ1

  // ****************************************
  // Bit engine
  // ****************************************
  assign byte_done = sclk_rise & (bit_cnt == `NP_BYTE_LAST_BIT); // RQ19
  assign boundary  = (bit_cnt == `NP_BIT_FIRST) & ~armed;

  // Armed marks a rising edge seen in this byte; in mode 3 the falling
  // edge before the first rising one must not shift the first bit away
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bit_cnt  <= `NP_BIT_FIRST;
      armed    <= 1'b0;
      rx_shift <= 8'h00;
    end
    else if (!selected)
    begin
      bit_cnt <= `NP_BIT_FIRST;
      armed   <= 1'b0;
    end
    else if (sclk_rise)
    begin
      rx_shift <= {rx_shift[6:0], mosi_sync[1]}; // RQ19
      bit_cnt  <= 3'(bit_cnt + 1'b1);
      armed    <= (bit_cnt != `NP_BYTE_LAST_BIT);
    end
  end

  // Refills with ones; idles at ones while deselected so a cut frame leaves no stale bit
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_shift <= `NP_IDLE_BYTE;
    else if (!selected | ss_fall)
      tx_shift <= `NP_IDLE_BYTE; // RQ8
    else if (take_first | take_next)
      tx_shift <= fifo_word.data; // RQ11
    else if (byte_done)
      tx_shift <= `NP_IDLE_BYTE; // RQ10
    else if (sclk_fall & armed)
      tx_shift <= {tx_shift[6:0], 1'b1}; // RQ19
  end

  assign spi_miso_out    = tx_shift[7];
  assign spi_miso_oe_out = selected;

  // ****************************************
  // Response buffer
  // ****************************************
  np_byte_fifo
  #(
    .WIDTH ($bits(np_spi_pkg::rsp_word_t)),
    .DEPTH (`NP_RSP_FIFO_DEPTH)
  )
  u_rsp_fifo
  (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (abort),
    .in_valid_in   (rsp_valid_in),
    .in_ready_out  (rsp_ready_out),
    .in_data_in    (rsp_word_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_word)
  );

  // A response may open only with a byte other than 0xFF
  assign rsp_ready_now = (phase == np_spi_pkg::PH_WAIT) & fifo_valid
                       & (fifo_word.data != `NP_IDLE_BYTE) & ~ss_rise;
  assign skip_ff       = (phase == np_spi_pkg::PH_WAIT) & fifo_valid
                       & (fifo_word.data == `NP_IDLE_BYTE); // RQ14
  // Load at a byte boundary only; a paused clock lets it load at once
  assign take_first    = rsp_ready_now
                       & (byte_done | (boundary & ~sclk_rise)); // RQ11
  assign take_next     = (phase == np_spi_pkg::PH_RSP) & byte_done
                       & fifo_valid & ~ss_rise; // RQ16
  assign rsp_end       = take_next & (fifo_word.last
                       | (rsp_cnt == 8'(`NP_FRAME_MAX - 1'b1))); // RQ14
  assign pop           = take_first | take_next | skip_ff;
  assign abort         = ss_rise & (phase != np_spi_pkg::PH_IDLE)
                       & (phase != np_spi_pkg::PH_DONE); // RQ18

  // ****************************************
  // Transaction phases
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase <= np_spi_pkg::PH_IDLE;
    else if (ss_rise)
      phase <= np_spi_pkg::PH_IDLE; // RQ18
    else if (ss_fall)
      phase <= np_spi_pkg::PH_CMD; // RQ5
    else
    begin
      unique case (phase)
        np_spi_pkg::PH_IDLE:
          phase <= np_spi_pkg::PH_IDLE;
        np_spi_pkg::PH_CMD:
        begin
          if (cmd_end_in | (byte_done & (cmd_cnt == 8'(`NP_FRAME_MAX - 1'b1))))
            phase <= np_spi_pkg::PH_WAIT; // RQ6
        end
        np_spi_pkg::PH_WAIT:
        begin
          if (take_first)
            phase <= fifo_word.last ? np_spi_pkg::PH_TAIL : np_spi_pkg::PH_RSP;
        end
        np_spi_pkg::PH_RSP:
        begin
          if (rsp_end)
            phase <= np_spi_pkg::PH_TAIL;
        end
        np_spi_pkg::PH_TAIL:
        begin
          if (byte_done)
            phase <= np_spi_pkg::PH_DONE; // RQ16
        end
        np_spi_pkg::PH_DONE:
          phase <= np_spi_pkg::PH_DONE;
      endcase
    end
  end

  assign phase_out = phase;

  // ****************************************
  // Command bytes to the user side
  // ****************************************
  // No back-pressure here: the host cannot be stalled mid-byte
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_data_out  <= 8'h00;
      cmd_cnt       <= 8'h00;
    end
    else
    begin
      cmd_valid_out <= byte_done & (phase == np_spi_pkg::PH_CMD) & ~ss_rise;
      if (ss_fall)
        cmd_cnt <= 8'h00;
      else if (byte_done & (phase == np_spi_pkg::PH_CMD))
      begin
        cmd_data_out <= {rx_shift[6:0], mosi_sync[1]};
        cmd_cnt      <= 8'(cmd_cnt + 1'b1); // RQ7
      end
    end
  end

  // ****************************************
  // Response byte count
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rsp_cnt <= 8'h00;
    else if (ss_fall)
      rsp_cnt <= 8'h00;
    else if (take_first)
      rsp_cnt <= `NP_COUNT_ONE;
    else if (take_next)
      rsp_cnt <= 8'(rsp_cnt + 1'b1); // RQ14
  end

  // ****************************************
  // Wait phase supervision
  // ****************************************
  // Overrun is reported, not acted on: the host decides to reset us
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_cnt         <= '0;
      wait_overrun_out <= 1'b0;
    end
    else
    begin
      wait_overrun_out <= 1'b0;
      if (phase != np_spi_pkg::PH_WAIT)
        wait_cnt <= '0;
      else if (wait_cnt == `NP_WAIT_CNT_W'(WAIT_CYCLES - 1))
        wait_overrun_out <= 1'b1; // RQ9
      else
        wait_cnt <= `NP_WAIT_CNT_W'(wait_cnt + 1'b1); // RQ9
    end
  end

  // ****************************************
  // Host attention and wake
  // ****************************************
  // One falling edge per transaction; released on the next host clock
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      host_attention_n_out <= 1'b1;
      attn_armed           <= 1'b0;
    end
    else if (ss_fall)
    begin
      host_attention_n_out <= 1'b1;
      attn_armed           <= 1'b1;
    end
    else if (ss_rise)
    begin
      host_attention_n_out <= 1'b1; // RQ3
      attn_armed           <= 1'b0;
    end
    else if (!host_attention_n_out & sclk_rise)
      host_attention_n_out <= 1'b1; // RQ13
    else if (rsp_ready_now & attn_armed)
    begin
      host_attention_n_out <= 1'b0; // RQ12
      attn_armed           <= 1'b0;
    end
  end

  assign wake_pullup_en_out = 1'b1; // RQ4

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      wake_req_out <= 1'b0;
    else
      wake_req_out <= ~wake_sync[1]; // RQ3
  end

  // ****************************************
  // Transaction status pulses
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      txn_done_out     <= 1'b0;
      txn_abort_out    <= 1'b0;
      rsp_underrun_out <= 1'b0;
    end
    else
    begin
      txn_done_out     <= ss_rise & (phase == np_spi_pkg::PH_DONE); // RQ16
      txn_abort_out    <= abort; // RQ18
      rsp_underrun_out <= (phase == np_spi_pkg::PH_RSP) & byte_done & ~fifo_valid;
    end
  end

endmodule : np_spi_slave

`default_nettype wire

// *** test/np_spi_slave_assertions.sv ***
// Port checks for the SPI slave transaction engine
`default_nettype none
module np_spi_slave_assertions
(
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               spi_sclk_in,
  input wire logic               spi_ss_n_in,
  input wire logic               spi_miso_out,
  input wire logic               spi_miso_oe_out,
  input wire logic               host_attention_n_out,
  input wire logic               wake_request_n_in,
  input wire logic               wake_pullup_en_out,
  input wire logic               wake_req_out,
  input wire logic               cmd_valid_out,
  input wire logic               txn_done_out,
  input wire logic               txn_abort_out,
  input wire logic               wait_overrun_out,
  input wire np_spi_pkg::phase_t phase_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_cmd_miso_ones:
    assert property (phase_out inside {np_spi_pkg::PH_IDLE, np_spi_pkg::PH_CMD} |-> spi_miso_out)
    else $error("MISO not high before wait");
  chk_cmd_only_cmd:
    assert property (cmd_valid_out |-> $past(phase_out) == np_spi_pkg::PH_CMD)
    else $error("byte taken outside command");
  chk_quiet_unselected:
    assert property (spi_ss_n_in [*4] |-> !spi_miso_oe_out)
    else $error("MISO driven while unselected");
  chk_pullup_on:
    assert property (wake_pullup_en_out)
    else $error("wake pull-up off");
  chk_wake_follow:
    assert property ($stable(wake_request_n_in) [*4] |-> wake_req_out != wake_request_n_in)
    else $error("wake request polarity wrong");
  chk_attn_in_wait:
    assert property ($fell(host_attention_n_out) |-> $past(phase_out) == np_spi_pkg::PH_WAIT)
    else $error("attention outside wait");
  chk_attn_release:
    assert property (!host_attention_n_out && $rose(spi_sclk_in) && !spi_ss_n_in
      |-> ##[1:5] host_attention_n_out)
    else $error("attention not released");
  chk_abort_on_ss:
    assert property ($rose(spi_ss_n_in) && phase_out inside {np_spi_pkg::PH_CMD,
      np_spi_pkg::PH_WAIT, np_spi_pkg::PH_RSP, np_spi_pkg::PH_TAIL} |-> ##[1:5] txn_abort_out)
    else $error("early deselect not aborted");
  chk_done_on_ss:
    assert property ($rose(spi_ss_n_in) && phase_out == np_spi_pkg::PH_DONE
      |-> ##[1:5] txn_done_out)
    else $error("completed transaction not reported");
  cov_attn: cover property ($fell(host_attention_n_out));
  cov_done: cover property (txn_done_out);
  cov_abort: cover property (txn_abort_out);
  cov_overrun: cover property (wait_overrun_out);
endmodule : np_spi_slave_assertions

bind np_spi_slave np_spi_slave_assertions chk
(
  .clk_in, .rst_n_in, .spi_sclk_in, .spi_ss_n_in, .spi_miso_out, .spi_miso_oe_out,
  .host_attention_n_out, .wake_request_n_in, .wake_pullup_en_out, .wake_req_out,
  .cmd_valid_out, .txn_done_out, .txn_abort_out, .wait_overrun_out, .phase_out
);
`default_nettype wire

// *** test/np_spi_host_model.sv ***
// Behavioural SPI master standing in for the host controller
`default_nettype none
module np_spi_host_model
(
  input  wire logic clk_in,
  input  wire logic mode3_in,
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      ss_n_out,
  output logic      mosi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Half period of 4 cycles gives 160 ns, a 320 ns period below the 5 MHz ceiling
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half
  // Idle level set first so no stray edge lands inside the frame
  task automatic select();
    sclk_out = mode3_in;
    half();
    ss_n_out = 1'b0;
    half();
  endtask : select
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      mosi_out = tx[i];
      half();
      sclk_out = 1'b1;
      rx[i] = miso_in;
      half();
    end
  endtask : xfer
  // Released MOSI shows the inverse so a stale bit is never trusted
  task automatic deselect();
    sclk_out = mode3_in;
    half();
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (25000) @(negedge clk_in);
  endtask : deselect
endmodule : np_spi_host_model
`default_nettype wire

// *** test/tb_np_spi_slave.sv ***
// Self-checking bench for the SPI slave transaction engine
`default_nettype none
module tb_np_spi_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_n_in, spi_sclk_in, spi_ss_n_in, spi_mosi_in, spi_miso_out;
  logic spi_miso_oe_out, host_attention_n_out, wake_pullup_en_out, wake_req_out;
  logic cmd_valid_out, cmd_end_in, rsp_valid_in, rsp_ready_out, txn_done_out;
  logic txn_abort_out, wait_overrun_out, rsp_underrun_out, mode3, wake_low;
  logic                  [7:0] cmd_data_out;
  np_spi_pkg::rsp_word_t rsp_word_in;
  np_spi_pkg::phase_t    phase_out;
  logic                  [7:0] rnd = 8'h11;
  logic                  [7:0] got[$];
  bit                    attn_seen, done_seen, abort_seen, ovr_seen, und_seen;
  int                    mismatches = 0;
  int                    total_checks = 0;
  wire logic wake_request_n_in = wake_low ? 1'b0 : wake_pullup_en_out;
  wire logic miso_line = spi_miso_oe_out ? spi_miso_out : ~spi_miso_out;
  // ****
  // Design and host
  // ****
  np_spi_slave #(.WAIT_CYCLES(200)) dut
  (
    .clk_in, .rst_n_in, .spi_sclk_in, .spi_ss_n_in, .spi_mosi_in, .spi_miso_out,
    .spi_miso_oe_out, .host_attention_n_out, .wake_request_n_in, .wake_pullup_en_out,
    .wake_req_out, .cmd_valid_out, .cmd_data_out, .cmd_end_in, .rsp_valid_in,
    .rsp_ready_out, .rsp_word_in, .txn_done_out, .txn_abort_out, .wait_overrun_out,
    .rsp_underrun_out, .phase_out
  );
  np_spi_host_model host
  (
    .clk_in(clk_in), .mode3_in(mode3), .miso_in(miso_line),
    .sclk_out(spi_sclk_in), .ss_n_out(spi_ss_n_in), .mosi_out(spi_mosi_in)
  );
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Pulses are sampled at the falling edge, where outputs have settled
  always @(negedge clk_in)
  begin
    if (cmd_valid_out === 1'b1)
      got.push_back(cmd_data_out);
    attn_seen |= (host_attention_n_out === 1'b0);
    done_seen |= (txn_done_out === 1'b1);
    abort_seen |= (txn_abort_out === 1'b1);
    ovr_seen |= (wait_overrun_out === 1'b1);
    und_seen |= (rsp_underrun_out === 1'b1);
  end
  // ****
  // Helpers
  // ****
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rand
  // Leaves valid high so back-to-back words need no idle cycle
  task automatic push(input np_spi_pkg::rsp_word_t w);
    rsp_word_in = w;
    rsp_valid_in = 1'b1;
    while (rsp_ready_out !== 1'b1)
      @(negedge clk_in);
    @(negedge clk_in);
  endtask : push
  task automatic run_txn(input bit m3, input int ncmd, input bit early);
    np_spi_pkg::rsp_word_t rq[$];
    logic [7:0] exp_q[$];
    logic [7:0] rx;
    int n;
    n = early ? 6 : 3;
    mode3 = m3;
    got.delete();
    {attn_seen, done_seen, ovr_seen} = '0;
    for (int i = 0; i < n; i++)
    begin
      rnd = next_rand(rnd);
      rq.push_back({i == n - 1, (i == 0) ? rnd & 8'h7F : rnd});
    end
    host.select();
    for (int i = 0; i < ncmd; i++)
    begin
      rnd = next_rand(rnd);
      exp_q.push_back((i == 0) ? rnd & 8'h7F : rnd);
      host.xfer(exp_q[i], rx);
      check(rx, 8'hFF);
    end
    if (early)
    begin
      for (int i = 0; i < 4; i++)
        push(rq[i]);
      rsp_valid_in = 1'b0;
      check(rsp_ready_out, 1'b0);
    end
    repeat (4) @(negedge clk_in);
    cmd_end_in = 1'b1;
    @(negedge clk_in);
    cmd_end_in = 1'b0;
    check(9'(got.size()), 9'(ncmd));
    foreach (exp_q[i]) check(got[i], exp_q[i]);
    if (early)
    begin
      repeat (3) @(negedge clk_in);
      check(host_attention_n_out, 1'b0);
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        host.xfer(8'h5A, rx);
        check(rx, 8'hFF);
      end
      check(9'(got.size()), 9'(ncmd));
      check(ovr_seen, 1'b1);
    end
    fork
      begin
        for (int i = early ? 4 : 0; i < n; i++)
          push(rq[i]);
        rsp_valid_in = 1'b0;
      end
      begin
        rx = 8'hFF;
        for (int k = 0; k < 8 && rx == 8'hFF; k++)
          host.xfer(8'hFF, rx);
        check(host_attention_n_out, 1'b1);
        for (int i = 0; i < n; i++)
        begin
          if (i > 0)
            host.xfer(8'hFF, rx);
          check(rx, rq[i].data);
        end
      end
    join
    host.deselect();
    check(attn_seen, 1'b1);
    check(done_seen, 1'b1);
    check(phase_out, np_spi_pkg::PH_IDLE);
  endtask : run_txn
  // ****
  // Sequence
  // ****
  initial
  begin
    logic [7:0] rx;
    rst_n_in = 1'b0;
    cmd_end_in = 1'b0;
    rsp_valid_in = 1'b0;
    rsp_word_in = '0;
    mode3 = 1'b0;
    wake_low = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    check(host_attention_n_out, 1'b1);
    check(spi_miso_oe_out, 1'b0);
    wake_low = 1'b1;
    repeat (5) @(negedge clk_in);
    check(wake_req_out, 1'b1);
    wake_low = 1'b0;
    repeat (5) @(negedge clk_in);
    check(wake_req_out, 1'b0);
    run_txn(1'b0, 3, 1'b0);
    run_txn(1'b1, 5, 1'b1);
    // Cut inside the response: 0xFF head dropped, one byte sent, then an underrun
    got.delete();
    {abort_seen, und_seen} = '0;
    host.select();
    host.xfer(8'h3C, rx);
    host.xfer(8'h01, rx);
    cmd_end_in = 1'b1;
    @(negedge clk_in);
    cmd_end_in = 1'b0;
    push(9'h0FF);
    push(9'h042);
    rsp_valid_in = 1'b0;
    host.xfer(8'hFF, rx);
    check(rx, 8'h42);
    host.xfer(8'hFF, rx);
    check(rx, 8'hFF);
    host.deselect();
    check(abort_seen, 1'b1);
    check(und_seen, 1'b1);
    check(9'(got.size()), 9'h002);
    check(phase_out, np_spi_pkg::PH_IDLE);
    end_of_test();
  end
  // Three transactions with 1 ms spacing take about 3.1 ms
  initial
  begin
    #4000000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_np_spi_slave
`default_nettype wire
